//--- rtl/fcae_pkg.sv
package fcae_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CLKDIV = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	// Status register bit positions
	localparam int BIT_CBEF = 7;
	localparam int BIT_CCIF = 6;
	localparam int BIT_ACCESS_ERROR_BIT = 4;
	localparam int BIT_ABORT = 3;
	// Divider register layout
	localparam int DIV_W = 6;
	localparam int BIT_DIVLD = 7;
	// Command codes
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_SERASE = 8'h40;
	localparam logic [7:0] CMD_MERASE = 8'h41;
	localparam logic [7:0] CMD_ABORT = 8'h47;
	// Operation lengths in flash clock ticks
	localparam logic [15:0] TICKS_BLANK = 16'h0008;
	localparam logic [15:0] TICKS_PROG = 16'h0010;
	localparam logic [15:0] TICKS_SERASE = 16'h0040;
	localparam logic [15:0] TICKS_MERASE = 16'h0080;
	localparam logic [15:0] TICKS_ABORT = 16'h0004;
	// Values after reset
	localparam logic [7:0] RST_CLKDIV = 8'h00;
	localparam logic [7:0] RST_CMD = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [DIV_W-1:0] RST_DIVCNT = 6'h00;
	// Command entry and execution states
	typedef enum logic [2:0] {
		ENT_IDLE = 3'b001,
		ENT_ADDR = 3'b010,
		ENT_CMD = 3'b100
	} fcae_ent_type;
	typedef enum logic [2:0] {
		EX_IDLE = 3'b001,
		EX_RUN = 3'b010,
		EX_ABORT = 3'b100
	} fcae_ex_type;
endpackage

//--- rtl/fcae_seq_if.sv
`timescale 1ns/100ps
interface fcae_seq_if;
	logic [7:0] code;
	logic from_debug;
	logic secured;
	logic legal;
	logic denied;
	logic [15:0] ticks;
	logic [5:0] div_val;
	logic div_en;
	logic tick;
	modport core (output code, output from_debug, output secured, output div_val,
		output div_en, input legal, input denied, input ticks, input tick);
	modport dec (input code, input from_debug, input secured, output legal,
		output denied, output ticks);
	modport div (input div_val, input div_en, output tick);
endinterface

//--- rtl/fcae_code_check.sv
`timescale 1ns/100ps
module fcae_code_check (
	fcae_seq_if.dec sq
);
	import fcae_pkg::*;

	always_comb begin
		sq.legal = 1'b0;
		sq.ticks = TICKS_BLANK;
		unique case (sq.code)
			CMD_BLANK: begin
				sq.legal = 1'b1;
			end
			CMD_BYTE, CMD_BURST: begin
				sq.legal = 1'b1;
				sq.ticks = TICKS_PROG;
			end
			CMD_SERASE: begin
				sq.legal = 1'b1;
				sq.ticks = TICKS_SERASE;
			end
			CMD_MERASE: begin
				sq.legal = 1'b1;
				sq.ticks = TICKS_MERASE;
			end
			CMD_ABORT: begin
				sq.legal = 1'b1;
				sq.ticks = TICKS_ABORT;
			end
			default: begin
				sq.legal = 1'b0;
			end
		endcase
	end

	// Secured part: debug path may only blank check and mass erase
	assign sq.denied = sq.from_debug && sq.secured && (sq.code == CMD_BYTE ||
		sq.code == CMD_BURST || sq.code == CMD_SERASE || sq.code == CMD_ABORT);
endmodule

//--- rtl/fcae_clk_div.sv
`timescale 1ns/100ps
module fcae_clk_div (
	input wire logic mclk,
	input wire logic arst_n,
	fcae_seq_if.div sq
);
	import fcae_pkg::*;

	logic [DIV_W-1:0] cnt_r;
	logic tick_r;

	// Flash clock enable: one pulse every div_val+1 system cycles
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= RST_DIVCNT;
			tick_r <= 1'b0;
		end else if (!sq.div_en) begin
			cnt_r <= RST_DIVCNT;
			tick_r <= 1'b0;
		end else if (cnt_r >= sq.div_val) begin
			cnt_r <= RST_DIVCNT;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 6'h01;
			tick_r <= 1'b0;
		end
	end

	assign sq.tick = tick_r;
endmodule

//--- rtl/fcae_top.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module fcae_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bdc_access,
	input wire logic secured_pin,
	input wire logic stop_req_pin,
	output logic flash_busy,
	output logic [7:0] flash_op
);
	import fcae_pkg::*;

	fcae_seq_if sq ();

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic rd_hit;
	logic [7:0] div_r;
	logic div_written_r;
	logic [7:0] cmd_r;
	logic [15:0] addr_r;
	logic [7:0] ctrl_r;
	logic cbef_r;
	logic ccif_r;
	logic access_error_bit_r;
	logic err_set;
	logic launch;
	logic done;
	logic stop_kill;
	logic [15:0] count_r;
	logic [7:0] op_r;
	logic busy_r;
	logic [2:0] sec_sync_r;
	logic [2:0] stop_sync_r;
	logic secured_r;
	logic stop_r;
	fcae_ent_type ent_r;
	fcae_ex_type ex_r;
	logic wr_fire;
	logic w_clkdiv;
	logic w_status;
	logic w_cmd;
	logic w_addr;
	logic w_ctrl;
	logic pe_op;

	//////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, registered answer
	assign wr_fire = psel && penable && pready_r && pwrite;
	assign w_clkdiv = wr_fire && paddr == OFS_CLKDIV;
	assign w_status = wr_fire && paddr == OFS_STATUS;
	assign w_cmd = wr_fire && paddr == OFS_CMD;
	assign w_addr = wr_fire && paddr == OFS_ADDR;
	assign w_ctrl = wr_fire && paddr == OFS_CTRL;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (paddr)
			OFS_CLKDIV: begin
				rd_nxt[7:0] = {div_written_r, div_r[6:0]};
			end
			OFS_STATUS: begin
				rd_nxt[BIT_CBEF] = cbef_r;
				rd_nxt[BIT_CCIF] = ccif_r;
				rd_nxt[BIT_ACCESS_ERROR_BIT] = access_error_bit_r;
				rd_nxt[BIT_ABORT] = ex_r == EX_ABORT;
			end
			OFS_CMD: begin
				rd_nxt[7:0] = cmd_r;
			end
			OFS_ADDR: begin
				rd_nxt[15:0] = addr_r;
			end
			OFS_CTRL: begin
				rd_nxt[7:0] = ctrl_r;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (psel && penable && !pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= !rd_hit;
			prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sec_sync_r <= 3'h0;
			stop_sync_r <= 3'h0;
		end else begin
			sec_sync_r <= {sec_sync_r[1:0], secured_pin};
			stop_sync_r <= {stop_sync_r[1:0], stop_req_pin};
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			secured_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			if (sec_sync_r[1] == sec_sync_r[2]) begin
				secured_r <= sec_sync_r[2];
			end
			if (stop_sync_r[1] == stop_sync_r[2]) begin
				stop_r <= stop_sync_r[2];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Code checker and flash clock divider
	assign sq.code = (ent_r == ENT_ADDR) ? pwdata[7:0] : cmd_r;
	assign sq.from_debug = bdc_access;
	assign sq.secured = secured_r;
	assign sq.div_val = div_r[5:0];
	assign sq.div_en = div_written_r;

	fcae_code_check u_check (
		.sq(sq)
	);

	fcae_clk_div u_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.sq(sq)
	);

	//////////////////////////////////////////////////////////////////////////
	// Protocol checking
	assign pe_op = op_r != CMD_BLANK;
	assign stop_kill = stop_r && ex_r != EX_IDLE;

	always_comb begin
		err_set = 1'b0;
		if (wr_fire && !access_error_bit_r) begin
			unique case (ent_r)
				ENT_IDLE: begin
					if (w_addr && (!div_written_r || !cbef_r)) begin
						err_set = 1'b1;
					end
					if (w_addr && ex_r == EX_ABORT) begin
						err_set = 1'b1;
					end
					if (w_cmd) begin
						err_set = 1'b1;
					end
				end
				ENT_ADDR: begin
					if (w_addr) begin
						err_set = 1'b1;
					end else if (w_clkdiv || w_ctrl || (w_status && pwdata[BIT_CBEF])) begin
						err_set = 1'b1;
					end else if (w_status) begin
						err_set = 1'b1;
					end else if (w_cmd && (!sq.legal || sq.denied)) begin
						err_set = 1'b1;
					end else if (w_cmd && (ex_r == EX_RUN) != (pwdata[7:0] == CMD_ABORT)) begin
						err_set = 1'b1;
					end
				end
				ENT_CMD: begin
					if (w_cmd) begin
						err_set = 1'b1;
					end else if (w_addr || w_clkdiv || w_ctrl) begin
						err_set = 1'b1;
					end else if (w_status && !pwdata[BIT_CBEF]) begin
						err_set = 1'b1;
					end
				end
			endcase
		end
		if (stop_kill && pe_op) begin
			err_set = 1'b1;
		end
	end

	// Launch only from a complete entry with no pending error
	assign launch = w_status && pwdata[BIT_CBEF] && ent_r == ENT_CMD && !access_error_bit_r && !err_set;
	assign done = ex_r != EX_IDLE && sq.tick && count_r == 16'h0001 && !stop_r;

	//////////////////////////////////////////////////////////////////////////
	// Command entry sequence
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ent_r <= ENT_IDLE;
		end else if (err_set) begin
			ent_r <= ENT_IDLE;
		end else if (!access_error_bit_r) begin
			unique case (ent_r)
				ENT_IDLE: begin
					if (w_addr) begin
						ent_r <= ENT_ADDR;
					end
				end
				ENT_ADDR: begin
					if (w_cmd) begin
						ent_r <= ENT_CMD;
					end
				end
				ENT_CMD: begin
					if (launch) begin
						ent_r <= ENT_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= RST_ADDR;
			cmd_r <= RST_CMD;
		end else if (!access_error_bit_r && !err_set) begin
			if (w_addr && ent_r == ENT_IDLE) begin
				addr_r <= pwdata[15:0];
			end
			if (w_cmd && ent_r == ENT_ADDR) begin
				cmd_r <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= RST_CLKDIV;
			div_written_r <= 1'b0;
			ctrl_r <= RST_CTRL;
		end else begin
			if (w_clkdiv && ent_r == ENT_IDLE) begin
				div_r <= pwdata[7:0];
				div_written_r <= 1'b1;
			end
			if (w_ctrl && ent_r == ENT_IDLE) begin
				ctrl_r <= pwdata[7:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Command execution
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ex_r <= EX_IDLE;
			count_r <= RST_COUNT;
			op_r <= RST_CMD;
		end else if (stop_kill) begin
			ex_r <= EX_IDLE;
			count_r <= RST_COUNT;
		end else if (launch && cmd_r == CMD_ABORT) begin
			ex_r <= EX_ABORT;
			count_r <= sq.ticks;
		end else if (launch) begin
			ex_r <= EX_RUN;
			count_r <= sq.ticks;
			op_r <= cmd_r;
		end else if (done) begin
			ex_r <= EX_IDLE;
			count_r <= RST_COUNT;
		end else if (ex_r != EX_IDLE && sq.tick) begin
			count_r <= count_r - 16'h0001;
		end
	end

	// Sector erase frees the buffer at once so only an abort may follow
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cbef_r <= 1'b1;
		end else if (launch) begin
			cbef_r <= cmd_r == CMD_SERASE;
		end else if (done || stop_kill) begin
			cbef_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ccif_r <= 1'b1;
		end else if (launch) begin
			ccif_r <= 1'b0;
		end else if (done || stop_kill) begin
			ccif_r <= 1'b1;
		end
	end

	// Set wins over the software clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			access_error_bit_r <= 1'b0;
		end else if (err_set) begin
			access_error_bit_r <= 1'b1;
		end else if (w_status && pwdata[BIT_ACCESS_ERROR_BIT]) begin
			access_error_bit_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= (ex_r != EX_IDLE || launch) && !done && !stop_kill;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign flash_busy = busy_r;
	assign flash_op = op_r;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	chk_abort_keeps_cbef: assert property ((launch && cmd_r == CMD_ABORT) |=> !cbef_r [*2])
		else $error("buffer empty flag set by abort launch");
	chk_abort_entry_err: assert property ((w_addr && ex_r == EX_ABORT) |=> access_error_bit_r)
		else $error("entry during abort not flagged");
	chk_err_blocks: assert property (access_error_bit_r |-> !launch && !$rose(ex_r == EX_RUN))
		else $error("command launched with access error set");
	chk_err_clear: assert property ((access_error_bit_r && w_status && pwdata[BIT_ACCESS_ERROR_BIT]
		&& !err_set) |=> !access_error_bit_r)
		else $error("access error not cleared by write of one");
	chk_div_first: assert property ((w_addr && !div_written_r) |=> access_error_bit_r)
		else $error("address before divider not flagged");
	chk_full_addr: assert property ((w_addr && !cbef_r) |=> access_error_bit_r)
		else $error("address with full buffer not flagged");
	chk_second_addr: assert property ((w_addr && ent_r != ENT_IDLE) |=> access_error_bit_r)
		else $error("second address write not flagged");
	chk_second_cmd: assert property ((w_cmd && ent_r == ENT_CMD) |=> access_error_bit_r)
		else $error("second command write not flagged");
	chk_after_addr: assert property ((ent_r == ENT_ADDR && (w_ctrl || w_clkdiv))
		|=> access_error_bit_r && ent_r == ENT_IDLE)
		else $error("control write after address not flagged");
	chk_bad_code: assert property ((w_cmd && ent_r == ENT_ADDR && !sq.legal) |=> access_error_bit_r)
		else $error("illegal command code not flagged");
	chk_after_cmd: assert property ((ent_r == ENT_CMD && (w_ctrl || w_addr)) |=> access_error_bit_r)
		else $error("control write after command not flagged");
	chk_stop_abort: assert property ((stop_kill && pe_op) |=> ex_r == EX_IDLE && access_error_bit_r)
		else $error("stop did not abort program or erase");
	chk_secure_deny: assert property ((w_cmd && ent_r == ENT_ADDR && bdc_access && secured_r
		&& pwdata[7:0] == CMD_BYTE) |=> access_error_bit_r)
		else $error("secured debug program not flagged");
	chk_cancel_err: assert property ((w_status && !pwdata[BIT_CBEF] && ent_r != ENT_IDLE)
		|=> access_error_bit_r ##1 ent_r == ENT_IDLE)
		else $error("partial command cancel not flagged");
	chk_err_discard: assert property (err_set |=> ent_r == ENT_IDLE && $stable(cmd_r))
		else $error("partial command kept after error");
	chk_apb_answer: assert property ((psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
		else $error("slave answer not one wait state");
endmodule

//--- testbench/fcae_apb_host.sv
`timescale 1ns/100ps
module fcae_apb_host (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int n_timeout;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_timeout = 0;
	end
	////////////////////////////////////////////////////////////////////////////
	// Called just after a rising edge; holds the request until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) n_timeout++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep showing the last value
		paddr <= ~a;
		pwdata <= ~d;
		// One idle edge so a following call never drives psel twice in a step
		@(posedge mclk);
	endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
	import fcae_pkg::*;
	logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic bdc_access, secured_pin, stop_req_pin, flash_busy;
	logic [7:0] paddr, flash_op;
	logic [31:0] pwdata, prdata;
	int n_mismatch, checked;
	logic [7:0] bad[4] = '{8'h00, 8'h21, 8'h48, 8'hff};
	logic [7:0] good[4] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_MERASE};
	logic [7:0] dbg[4] = '{CMD_BYTE, CMD_BURST, CMD_SERASE, CMD_ABORT};
	fcae_top i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bdc_access(bdc_access),
		.secured_pin(secured_pin), .stop_req_pin(stop_req_pin),
		.flash_busy(flash_busy), .flash_op(flash_op));
	fcae_apb_host i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		n_mismatch += i_host.n_timeout;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdw(input logic [7:0] a, output logic [31:0] rd, output logic e);
		i_host.xfer(1'b0, a, 32'h0, rd, e);
		if (i_host.n_timeout > 0) end_of_test;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		i_host.xfer(1'b1, a, d, rd, e);
		if (i_host.n_timeout > 0) end_of_test;
	endtask
	// Reads the error bit; when an error is expected, clears it and confirms the clear
	task automatic acc_chk(input string what, input logic exp);
		logic [31:0] s;
		logic e;
		rdw(OFS_STATUS, s, e);
		chk(what, 32'(s[BIT_ACCESS_ERROR_BIT]), 32'(exp));
		if (exp) begin
			wr(OFS_STATUS, 32'h1 << BIT_ACCESS_ERROR_BIT);
			rdw(OFS_STATUS, s, e);
			chk("access_error_bit clear", 32'(s[BIT_ACCESS_ERROR_BIT]), 32'h0);
		end
	endtask
	task automatic cmd_run(input logic [7:0] code);
		wr(OFS_ADDR, 32'h1234);
		wr(OFS_CMD, 32'(code));
		wr(OFS_STATUS, 32'h1 << BIT_CBEF);
	endtask
	task automatic wait_idle;
		int i;
		i = 0;
		while (flash_busy !== 1'b0 && i < 3000) begin
			@(posedge mclk);
			i++;
		end
		if (i >= 3000) begin
			n_mismatch++;
			$display("Error wait_idle expected 0 seen 1");
			end_of_test;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic sc_setup;
		logic [31:0] s;
		logic e;
		rdw(OFS_STATUS, s, e);
		chk("status rst", s, 32'h0c0);
		rdw(8'h14, s, e);
		chk("unmapped err", 32'(e), 32'h1);
		wr(OFS_ADDR, 32'h10);
		acc_chk("no divider", 1'b1);
		wr(OFS_CLKDIV, 32'h3);
		rdw(OFS_CLKDIV, s, e);
		chk("divider", s, 32'h83);
		wr(OFS_ADDR, 32'h10);
		wr(OFS_ADDR, 32'h10);
		cmd_run(CMD_BLANK);
		repeat (2) @(posedge mclk);
		chk("busy blocked", 32'(flash_busy), 32'h0);
		acc_chk("second addr", 1'b1);
	endtask
	task automatic sc_order;
		wr(OFS_ADDR, 32'h20);
		wr(OFS_CMD, 32'(CMD_BLANK));
		wr(OFS_CMD, 32'(CMD_BLANK));
		acc_chk("second cmd", 1'b1);
		wr(OFS_ADDR, 32'h20);
		wr(OFS_CTRL, 32'h1);
		acc_chk("ctrl after addr", 1'b1);
		wr(OFS_ADDR, 32'h20);
		wr(OFS_CMD, 32'(CMD_BLANK));
		wr(OFS_CTRL, 32'h1);
		acc_chk("ctrl after cmd", 1'b1);
		wr(OFS_ADDR, 32'h20);
		wr(OFS_CMD, 32'(CMD_BLANK));
		wr(OFS_CLKDIV, 32'h3);
		acc_chk("div after cmd", 1'b1);
		wr(OFS_ADDR, 32'h20);
		wr(OFS_STATUS, 32'h0);
		acc_chk("cancel", 1'b1);
		wr(OFS_ADDR, 32'h20);
		wr(OFS_CMD, 32'(CMD_BLANK));
		wr(OFS_STATUS, 32'h0);
		acc_chk("cancel cmd", 1'b1);
	endtask
	task automatic sc_codes;
		foreach (bad[i]) begin
			wr(OFS_ADDR, 32'h30);
			wr(OFS_CMD, 32'(bad[i]));
			acc_chk("bad code", 1'b1);
		end
		foreach (good[i]) begin
			cmd_run(good[i]);
			repeat (2) @(posedge mclk);
			chk("busy", 32'(flash_busy), 32'h1);
			wait_idle();
			chk("op", 32'(flash_op), 32'(good[i]));
			acc_chk("good code", 1'b0);
		end
	endtask
	task automatic sc_abort;
		logic [31:0] s;
		logic e;
		cmd_run(CMD_BYTE);
		wr(OFS_ADDR, 32'h40);
		acc_chk("addr busy", 1'b1);
		wait_idle();
		// Aborts cost an erase cycle, so this bench uses one only
		cmd_run(CMD_SERASE);
		repeat (2) @(posedge mclk);
		cmd_run(CMD_ABORT);
		rdw(OFS_STATUS, s, e);
		chk("cbef abort", 32'(s[BIT_CBEF]), 32'h0);
		chk("abort bit", 32'(s[BIT_ABORT]), 32'h1);
		wr(OFS_ADDR, 32'h40);
		acc_chk("entry in abort", 1'b1);
		wait_idle();
	endtask
	task automatic sc_secure;
		secured_pin <= 1'b1;
		bdc_access <= 1'b1;
		repeat (6) @(posedge mclk);
		foreach (dbg[i]) begin
			wr(OFS_ADDR, 32'h50);
			wr(OFS_CMD, 32'(dbg[i]));
			acc_chk("secured code", 1'b1);
		end
		cmd_run(CMD_MERASE);
		wait_idle();
		acc_chk("secured mass", 1'b0);
		secured_pin <= 1'b0;
		bdc_access <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	task automatic sc_stop;
		cmd_run(CMD_SERASE);
		repeat (2) @(posedge mclk);
		stop_req_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("stop busy", 32'(flash_busy), 32'h0);
		stop_req_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		acc_chk("stop err", 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		bdc_access = 1'b0;
		secured_pin = 1'b0;
		stop_req_pin = 1'b0;
		n_mismatch = 0;
		checked = 0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		sc_setup();
		sc_order();
		sc_codes();
		sc_abort();
		sc_secure();
		sc_stop();
		end_of_test();
	end
endmodule
